// >>> hdl/emr_map.vh
/*
  Register map, field positions, reset values and timing counts of the MAC
  interrupt, PHY management, pause and hash filter register bank.
  Assumes a 32-bit APB with byte addresses and word-aligned registers.
*/
`ifndef EMR_MAP_VH
`define EMR_MAP_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define EMR_OFF_IRQ_STATUS 8'h00
`define EMR_OFF_IRQ_CLEAR 8'h04
`define EMR_OFF_IRQ_ENABLE 8'h08
`define EMR_OFF_IRQ_DISABLE 8'h0C
`define EMR_OFF_IRQ_MASK 8'h10
`define EMR_OFF_PHY_MGMT 8'h14
`define EMR_OFF_HASH_LOW 8'h18
`define EMR_OFF_HASH_HIGH 8'h1C
`define EMR_OFF_MATCH1_LOW 8'h20
`define EMR_OFF_MGMT_BUSY 8'h24
`define EMR_OFF_PAUSE 8'h38

// ----------------------------------------------------------------------
// interrupt source bits
// ----------------------------------------------------------------------
`define EMR_IRQ_VALID 32'h00003CFF
`define EMR_BIT_MGMT_DONE 0
`define EMR_BIT_PAUSE_ZERO 13

// ----------------------------------------------------------------------
// management frame fields
// ----------------------------------------------------------------------
`define EMR_MGMT_SOF_HI 31
`define EMR_MGMT_SOF_LO 30
`define EMR_MGMT_OP_HI 29
`define EMR_MGMT_OP_LO 28
`define EMR_MGMT_DATA_HI 15
`define EMR_MGMT_SOF_OK 2'h1
`define EMR_MGMT_OP_READ 2'h2
`define EMR_MGMT_OP_WRITE 2'h1
`define EMR_MGMT_RD_RELEASE 7'h2E
`define EMR_MGMT_RD_SAMPLE 7'h30
`define EMR_MGMT_LAST_BIT 7'h3F

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define EMR_RST_ZERO 32'h00000000
`define EMR_RST_MASK 32'h00003CFF
`define EMR_PREAMBLE 32'hFFFFFFFF
`define EMR_PAUSE_QUANTUM_BITS 512
`define EMR_MDC_HALF_CYCLES 8'h28

`endif

// >>> hdl/emr_regs.v
/*
  APB register bank of an Ethernet MAC: interrupt status, enable, disable
  and mask, the PHY management frame engine, the pause time counter, the
  64-bit multicast hash filter and the first specific address bottom word.
  Assumes event pulses and bit_tick come from MAC logic on pclk; only the
  management data input comes from a pin and is synchronised here.
*/
// Added by the designer: the APB slave port and the register offsets.
`include "emr_map.vh"

module emr_regs (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [13:0] mac_events,
    input wire pausing,
    input wire bit_tick,
    output reg irq,
    output reg [63:0] hash_filter,
    output reg [31:0] match_addr1,
    output reg mdc,
    output reg mdio_out,
    output reg mdio_oe,
    input wire mdio_in
);

    // ------------------------------------------------------------------
    // state and declarations
    // ------------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_SHIFT = 1'b1;

    reg [31:0] irq_status;
    reg [31:0] irq_mask_state;
    reg [31:0] phy_mgmt_frame;
    reg [15:0] pause_time;
    reg [8:0] quantum_cnt;
    reg mgmt_state;
    reg [63:0] mgmt_shift;
    reg [6:0] mgmt_bit;
    reg [7:0] mdc_div;
    reg [15:0] mgmt_capture;
    reg mgmt_is_read;
    reg mdio_meta;
    reg mdio_sync;
    reg mgmt_done_pulse;
    reg pause_zero_pulse;
    reg [31:0] next_status;
    reg [31:0] next_mask;
    reg [31:0] read_mux;
    reg read_hit;

    wire access = psel & penable & ~pready;
    wire wr = access & pwrite;
    wire wr_mgmt = wr && (paddr == `EMR_OFF_PHY_MGMT);
    wire [1:0] wr_sof = pwdata[`EMR_MGMT_SOF_HI:`EMR_MGMT_SOF_LO];
    wire [1:0] wr_op = pwdata[`EMR_MGMT_OP_HI:`EMR_MGMT_OP_LO];
    // invalid frames (bad start or op code) are stored but never sent
    wire op_valid = (wr_op == `EMR_MGMT_OP_READ) || (wr_op == `EMR_MGMT_OP_WRITE);
    wire frame_go = wr_mgmt && (mgmt_state == ST_IDLE) && op_valid &&
        (wr_sof == `EMR_MGMT_SOF_OK);
    // the divider is fixed: a different pclk needs a new half-period count
    wire mdc_edge = (mdc_div == `EMR_MDC_HALF_CYCLES);
    // the quantum is a plain integer, so cut the end count to the counter width
    wire [31:0] quantum_full = `EMR_PAUSE_QUANTUM_BITS - 1;
    wire [8:0] quantum_last = quantum_full[8:0];

    // ------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------
    // enable and disable only reach valid bits; reserved mask bits stay clear
    always @* begin
        next_status = irq_status;
        next_mask = irq_mask_state;
        if (wr && paddr == `EMR_OFF_IRQ_CLEAR) begin
            next_status = irq_status & ~pwdata;
        end
        if (wr && paddr == `EMR_OFF_IRQ_ENABLE) begin
            next_mask = irq_mask_state & ~(pwdata & `EMR_IRQ_VALID);
        end
        if (wr && paddr == `EMR_OFF_IRQ_DISABLE) begin
            next_mask = irq_mask_state | (pwdata & `EMR_IRQ_VALID);
        end
        // a new event wins over a clear in the same cycle
        next_status = next_status | ({18'h00000, mac_events} & `EMR_IRQ_VALID);
        if (mgmt_done_pulse) begin
            next_status[`EMR_BIT_MGMT_DONE] = 1'b1;
        end
        if (pause_zero_pulse) begin
            next_status[`EMR_BIT_PAUSE_ZERO] = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= `EMR_RST_ZERO;
            irq_mask_state <= `EMR_RST_MASK;
            irq <= 1'b0;
        end else begin
            irq_status <= next_status;
            irq_mask_state <= next_mask;
            // tx_buffers_exhausted (bit 6) is gated like every source
            irq <= |(next_status & ~next_mask);
        end
    end

    // ------------------------------------------------------------------
    // apb slave: one wait state so every answer comes from a flip-flop
    // ------------------------------------------------------------------
    always @* begin
        read_hit = 1'b1;
        read_mux = `EMR_RST_ZERO;
        case (paddr)
            `EMR_OFF_IRQ_STATUS: read_mux = irq_status;
            `EMR_OFF_IRQ_MASK: read_mux = irq_mask_state;
            `EMR_OFF_PHY_MGMT: read_mux = phy_mgmt_frame;
            `EMR_OFF_PAUSE: read_mux = {16'h0000, pause_time};
            `EMR_OFF_HASH_LOW: read_mux = hash_filter[31:0];
            `EMR_OFF_HASH_HIGH: read_mux = hash_filter[63:32];
            `EMR_OFF_MATCH1_LOW: read_mux = match_addr1;
            `EMR_OFF_MGMT_BUSY: read_mux = {31'h00000000, mgmt_state};
            // write-only registers read as zero
            `EMR_OFF_IRQ_CLEAR: read_mux = `EMR_RST_ZERO;
            `EMR_OFF_IRQ_ENABLE: read_mux = `EMR_RST_ZERO;
            `EMR_OFF_IRQ_DISABLE: read_mux = `EMR_RST_ZERO;
            default: read_hit = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `EMR_RST_ZERO;
        end else begin
            // one wait state: pready is a pulse, never held
            pready <= access;
            pslverr <= access & ~read_hit;
            // prdata keeps the last read between transfers
            if (access && !pwrite) begin
                prdata <= read_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // hash filter and specific address
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hash_filter <= {`EMR_RST_ZERO, `EMR_RST_ZERO};
            match_addr1 <= `EMR_RST_ZERO;
        end else begin
            if (wr && paddr == `EMR_OFF_HASH_LOW) begin
                hash_filter[31:0] <= pwdata;
            end
            if (wr && paddr == `EMR_OFF_HASH_HIGH) begin
                hash_filter[63:32] <= pwdata;
            end
            if (wr && paddr == `EMR_OFF_MATCH1_LOW) begin
                // bit 0 faces the first received byte's multicast bit
                match_addr1 <= pwdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // pause time counter
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_time <= 16'h0000;
            quantum_cnt <= 9'h000;
            pause_zero_pulse <= 1'b0;
        end else begin
            pause_zero_pulse <= 1'b0;
            // a reload restarts the quantum so the new count gets full bit times
            if (wr && paddr == `EMR_OFF_PAUSE) begin
                pause_time <= pwdata[15:0];
                quantum_cnt <= 9'h000;
            end else if (pausing && bit_tick && pause_time != 16'h0000) begin
                if (quantum_cnt == quantum_last) begin
                    quantum_cnt <= 9'h000;
                    pause_time <= pause_time - 16'h0001;
                    if (pause_time == 16'h0001) begin
                        pause_zero_pulse <= 1'b1;
                    end
                end else begin
                    quantum_cnt <= quantum_cnt + 9'h001;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // management frame engine
    // ------------------------------------------------------------------
    // the data pin is only looked at through the second stage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mdio_meta <= 1'b0;
            mdio_sync <= 1'b0;
        end else begin
            mdio_meta <= mdio_in;
            mdio_sync <= mdio_meta;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mgmt_state <= ST_IDLE;
            phy_mgmt_frame <= `EMR_RST_ZERO;
            mgmt_shift <= {`EMR_RST_ZERO, `EMR_RST_ZERO};
            mgmt_bit <= 7'h00;
            mdc_div <= 8'h00;
            mgmt_capture <= 16'h0000;
            mgmt_is_read <= 1'b0;
            mgmt_done_pulse <= 1'b0;
            mdc <= 1'b0;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
        end else begin
            mgmt_done_pulse <= 1'b0;
            case (mgmt_state)
                ST_IDLE: begin
                    mdc <= 1'b0;
                    mdio_oe <= 1'b0;
                    mdc_div <= 8'h00;
                    // a write while a frame runs is dropped to keep it intact
                    if (wr_mgmt) begin
                        phy_mgmt_frame <= pwdata;
                    end
                    if (frame_go) begin
                        // sof, op, phy_address, register select, code, data
                        mgmt_shift <= {`EMR_PREAMBLE, pwdata};
                        mgmt_is_read <= (wr_op == `EMR_MGMT_OP_READ);
                        mgmt_bit <= 7'h00;
                        mdio_out <= 1'b1;
                        mdio_oe <= 1'b1;
                        mgmt_state <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    mdc_div <= mdc_edge ? 8'h00 : mdc_div + 8'h01;
                    if (mdc_edge) begin
                        mdc <= ~mdc;
                        if (!mdc) begin
                            // rising edge of the clock: sample the read data the PHY drove on the fall
                            // the synchroniser adds two cycles, far inside a half period
                            if (mgmt_is_read && mgmt_bit >= `EMR_MGMT_RD_SAMPLE) begin
                                mgmt_capture <= {mgmt_capture[14:0], mdio_sync};
                            end
                        end else if (mgmt_bit == `EMR_MGMT_LAST_BIT) begin
                            mgmt_state <= ST_IDLE;
                            mdio_oe <= 1'b0;
                            mgmt_done_pulse <= 1'b1;
                            if (mgmt_is_read) begin
                                phy_mgmt_frame[`EMR_MGMT_DATA_HI:0] <= mgmt_capture;
                            end
                        end else begin
                            mgmt_shift <= {mgmt_shift[62:0], 1'b0};
                            mgmt_bit <= mgmt_bit + 7'h01;
                            mdio_out <= mgmt_shift[62];
                            // release the line for turnaround and read data
                            if (mgmt_is_read && mgmt_bit + 7'h01 >= `EMR_MGMT_RD_RELEASE) begin
                                mdio_oe <= 1'b0;
                            end
                        end
                    end
                end
                default: mgmt_state <= ST_IDLE;
            endcase
        end
    end

endmodule

// >>> verif/emr_phy_model.sv
/*
  Behavioural PHY on the management pins: 32 registers at one address.
  Assumes 32 preamble ones, then 32 frame bits MSB first, data on mdc fall.
*/
module emr_phy_model #(parameter logic [4:0] PHY_ADDR = 5'h03) (
    input wire mdc,
    input wire mdio_out,
    input wire mdio_oe,
    output logic mdio_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [32];
    logic [31:0] hdr = 32'h0;
    logic [15:0] rdv = 16'h0;
    logic drv = 1'b0;
    logic bitv = 1'b0;
    int n = 64;
    // pull-up: a line nobody drives reads high
    assign mdio_in = drv ? bitv : (mdio_oe ? mdio_out : 1'b1);
    initial for (int i = 0; i < 32; i++) mem[i] = 16'h0000;
    always @(posedge mdio_oe) if (n >= 64) n = 0;
    always @(posedge mdc) if (n < 64) begin
        if (n >= 32) hdr = {hdr[30:0], mdio_out};
        if (n == 47 && hdr[13:12] == 2'b10 && hdr[11:7] == PHY_ADDR) begin
            rdv = mem[hdr[6:2]];
            drv = 1'b1;
        end
        if (n == 63 && hdr[29:28] == 2'b01 && hdr[27:23] == PHY_ADDR)
            mem[hdr[22:18]] = hdr[15:0];
        n++;
    end
    // held until the fall after the last bit so the sampling rise is covered
    always @(negedge mdc) begin
        if (n >= 64) drv = 1'b0;
        else if (drv) bitv = rdv[63 - n];
    end
endmodule

// >>> verif/emr_regs_assertions.sv
/*
  Port-level checks of the MAC register bank, bound into emr_regs.
  Assumes the map header and the hand-over timing of the APB and frame logic.
*/
`include "emr_map.vh"
module emr_regs_assertions (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq,
    input wire [63:0] hash_filter,
    input wire [31:0] match_addr1,
    input wire mdc,
    input wire mdio_out,
    input wire mdio_oe
);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr_done = pready && psel && pwrite && !pslverr;
    wire [3:0] lead = pwdata[31:28];
    a_ready_after: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("error read with data");
    a_hash_low: assert property (wr_done && paddr == `EMR_OFF_HASH_LOW |->
        hash_filter[31:0] == pwdata) else $error("hash low not written");
    a_hash_high: assert property (wr_done && paddr == `EMR_OFF_HASH_HIGH |->
        hash_filter[63:32] == pwdata) else $error("hash high not written");
    a_match_low: assert property (wr_done && paddr == `EMR_OFF_MATCH1_LOW |->
        match_addr1 == pwdata) else $error("match word not written");
    a_irq_disable: assert property (wr_done && paddr == `EMR_OFF_IRQ_DISABLE &&
        pwdata[13:0] == 14'h3CFF |-> !irq) else $error("irq after full disable");
    a_frame_start: assert property (wr_done && paddr == `EMR_OFF_PHY_MGMT &&
        !$past(mdio_oe) && !$past(mdc) && (lead == 4'h5 || lead == 4'h6) |->
        ##[0:2] mdio_oe) else $error("frame not started");
    a_frame_drop: assert property (wr_done && paddr == `EMR_OFF_PHY_MGMT &&
        !$past(mdio_oe) && !$past(mdc) && (lead == 4'h7 || lead == 4'h4 || lead == 4'h9)
        |-> !mdio_oe [*3]) else $error("invalid frame sent");
    a_preamble_one: assert property ($rose(mdio_oe) |-> mdio_out)
        else $error("frame does not open with a one");
    a_mdc_steady: assert property ($changed(mdc) |=> $stable(mdc) [*8])
        else $error("management clock too fast");
endmodule
bind emr_regs emr_regs_assertions chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .hash_filter, .match_addr1, .mdc,
    .mdio_out, .mdio_oe);

// >>> verif/emr_regs_tb.sv
/*
  Self-checking bench of the MAC register bank with a PHY model.
  Assumes the map header; pclk at 200 MHz.
*/
`include "emr_map.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module emr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pausing = 0, bit_tick = 0;
    logic pready, pslverr, irq, mdc, mdio_out, mdio_oe, mdio_in, er;
    logic [7:0] paddr = 8'h00;
    logic [7:0] ha [3] = '{`EMR_OFF_HASH_LOW, `EMR_OFF_HASH_HIGH, `EMR_OFF_MATCH1_LOW};
    logic [13:0] mac_events = 14'h0;
    logic [15:0] d1;
    logic [31:0] pwdata = 32'h0, prdata, rd, frm, pv, rnd = 32'h8763A71A, st_m = 32'h0;
    logic [31:0] mk_m = `EMR_RST_MASK;
    logic [31:0] match_addr1;
    logic [63:0] hash_filter;
    int err_count = 0, comparisons = 0, t;
    emr_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .mac_events, .pausing, .bit_tick, .irq, .hash_filter,
        .match_addr1, .mdc, .mdio_out, .mdio_oe, .mdio_in);
    emr_phy_model phy_u (.mdc, .mdio_out, .mdio_oe, .mdio_in);
    // ------------------------------------------------------------------
    // bus, model and closing tasks
    // ------------------------------------------------------------------
    initial forever #2.5 pclk = ~pclk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) err_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rg(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (a == `EMR_OFF_IRQ_CLEAR) st_m &= ~d;
        if (a == `EMR_OFF_IRQ_ENABLE) mk_m &= ~d;
        if (a == `EMR_OFF_IRQ_DISABLE) mk_m |= d & `EMR_IRQ_VALID;
    endtask
    task automatic ck_irq;
        #1;
        `CHK(irq, |(st_m & ~mk_m))
    endtask
    task automatic ev(input logic [13:0] e);
        mac_events <= e;
        @(posedge pclk);
        mac_events <= 14'h0;
        st_m |= e & `EMR_IRQ_VALID;
        @(posedge pclk);
        ck_irq;
    endtask
    task automatic tick(input int k);
        repeat (k) begin
            bit_tick <= 1'b1;
            @(posedge pclk);
            bit_tick <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic frame(input logic [3:0] so, input logic [4:0] ra, input logic [15:0] d);
        frm = {so, 5'h03, ra, 2'b10, d};
        wr(`EMR_OFF_PHY_MGMT, frm);
        t = 0;
        do begin
            rg(`EMR_OFF_MGMT_BUSY);
            t++;
        end while (rd[0] !== 1'b0 && t < 3000);
        if (rd[0] !== 1'b0) err_count++;
        if (so == 4'h5 || so == 4'h6) st_m |= 32'h1;
        rg(`EMR_OFF_IRQ_STATUS);
        `CHK(rd, st_m)
        wr(`EMR_OFF_IRQ_CLEAR, 32'h1);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // a whole run is some 18k cycles
    initial begin
        #400000;
        err_count++;
        test_done;
    end
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rg(`EMR_OFF_IRQ_MASK);
        `CHK(rd, mk_m)
        wr(`EMR_OFF_IRQ_MASK, 32'h0);
        rg(`EMR_OFF_IRQ_MASK);
        `CHK(rd, mk_m)
        for (int b = 0; b < 14; b++) begin
            rnd = lfsr(rnd);
            wr(`EMR_OFF_IRQ_ENABLE, rnd | (32'h1 << b));
            ev(14'h1 << b);
            rg(`EMR_OFF_IRQ_STATUS);
            `CHK(rd, st_m)
            wr(`EMR_OFF_IRQ_DISABLE, 32'h1 << b);
            rg(`EMR_OFF_IRQ_MASK);
            `CHK(rd, mk_m)
            ck_irq;
            wr(`EMR_OFF_IRQ_CLEAR, 32'hFFFFFFFF);
        end
        wr(`EMR_OFF_IRQ_ENABLE, 32'hFFFFFFFF);
        ev(14'h3FFF);
        wr(`EMR_OFF_IRQ_DISABLE, 32'h3CFF);
        ck_irq;
        wr(`EMR_OFF_IRQ_CLEAR, 32'hFFFFFFFF);
        $display("test irq done");
        foreach (ha[i]) begin
            rnd = lfsr(rnd);
            wr(ha[i], rnd);
            rg(ha[i]);
            `CHK(rd, rnd)
            pv = i == 0 ? hash_filter[31:0] : i == 1 ? hash_filter[63:32] : match_addr1;
            `CHK(pv, rnd)
        end
        wr(8'h3C, rnd);
        `CHK(er, 1'b1)
        rg(8'h3C);
        `CHK({er, rd}, 33'h100000000)
        $display("test filter done");
        rnd = lfsr(rnd);
        d1 = rnd[15:0];
        frame(4'h5, 5'h05, d1);
        rg(`EMR_OFF_PHY_MGMT);
        `CHK(rd, frm)
        frame(4'h5, 5'h09, ~d1);
        frame(4'h6, 5'h05, 16'h0);
        rg(`EMR_OFF_PHY_MGMT);
        `CHK(rd, {frm[31:16], d1})
        frame(4'h7, 5'h05, d1);
        frame(4'h4, 5'h05, d1);
        frame(4'h9, 5'h05, d1);
        $display("test mgmt done");
        pausing <= 1'b1;
        wr(`EMR_OFF_PAUSE, 32'h2);
        tick(511);
        rg(`EMR_OFF_PAUSE);
        `CHK(rd, 32'h2)
        tick(1);
        rg(`EMR_OFF_PAUSE);
        `CHK(rd, 32'h1)
        tick(512);
        rg(`EMR_OFF_PAUSE);
        `CHK(rd, 32'h0)
        st_m |= 32'h2000;
        rg(`EMR_OFF_IRQ_STATUS);
        `CHK(rd, st_m)
        $display("test pause done");
        test_done;
    end
endmodule
